//--- core/csp_core_sfr.v
// core status, option, trim, program counter, return stack and indirect pointer logic
//
// Behaviour
// - arithmetic flags from result win over a same-cycle write
// - timeout and powerdown flags ignore software writes
// - wake flag loaded from reset cause after reset, also software writable
// - jump loads pc 8:0 plus page bit
// - option load instruction copies working register
// - reset sets option register to ones
// - output pins lose pull-up and wake
// - option bit7 active-low wake enable
// - option bit6 active-low pull-up enable
// - option bit5 selects timer clock source
// - option bit4 selects external counting edge
// - option bit3 assigns shared prescaler
// - rate field gives timer and watchdog ratios
// - trim register six bits, low two zero
// - pc increments each cycle unless loaded
// - call or pcl write clears pc bit 8
// - reset pc all ones, then wraps zero
// - reset clears page select bit
// - call pushes level1 to level2, pc+1 to level1
// - return pops level1, level2 copies down, literal
// - indirect location redirects to pointer address
// - pointer zero reads zero, self-write stores nothing
// - pointer 4:0 address, 6:5 bank
`timescale 1ns/1ps
`include "csp_defines.vh"
module csp_core_sfr (
  input wire clk_sys,
  input wire rst_n,
  input wire wake_reset_cause,
  input wire timeout_set,
  input wire timeout_clear,
  input wire powerdown_set,
  input wire powerdown_clear,
  input wire [4:0] file_addr,
  input wire file_wr,
  input wire [7:0] file_wdata,
  input wire flags_update,
  input wire [2:0] flags_result,
  output reg [7:0] file_rdata,
  output wire [6:0] mem_addr,
  output wire mem_sel,
  output wire mem_wr,
  input wire [7:0] mem_rdata,
  input wire [7:0] work_reg,
  input wire option_load,
  input wire jump_exec,
  input wire [8:0] jump_target,
  input wire call_exec,
  input wire [7:0] call_target,
  input wire return_exec,
  input wire [7:0] return_literal,
  output reg [7:0] return_work_data,
  output reg return_work_valid,
  input wire [3:0] pin_direction_control,
  output reg [11:0] pc_reg,
  output reg [11:0] stack_level1_reg,
  output reg [11:0] stack_level2_reg,
  output reg [7:0] option_reg,
  output reg [7:0] trim_reg,
  output reg [7:0] status_reg,
  output wire [3:0] pullup_active,
  output wire [3:0] wake_active,
  output wire timer_clock_source,
  output wire timer_edge_select,
  output wire prescaler_assign,
  output wire [8:0] timer_ratio,
  output wire [7:0] wdt_ratio
);
  reg [7:0] pointer_reg;
  reg [7:0] status_next;
  reg [11:0] pc_next;
  wire [11:0] pc_inc;
  wire ind_hit;
  wire [4:0] eff_addr;
  wire self_ref;
  wire [2:0] prescale_rate;
  reg cause_seen_reg;
  wire wake_flag_capture;
  genvar gi;

  assign ind_hit = (file_addr == `CSP_ADDR_INDIRECT);
  assign eff_addr = ind_hit ? pointer_reg[4:0] : file_addr;
  assign self_ref = ind_hit && (pointer_reg[4:0] == `CSP_ADDR_INDIRECT);
  assign mem_addr = {pointer_reg[6:5], eff_addr};
  assign mem_sel = !self_ref && (eff_addr > `CSP_ADDR_TRIM);
  assign mem_wr = file_wr && mem_sel;
  assign pc_inc = pc_reg + 12'h001;

  // read mux, indirect self-reference gives zero
  always @*
  begin
    file_rdata = 8'h00;
    if (self_ref)
      file_rdata = 8'h00;
    else
      case (eff_addr)
        `CSP_ADDR_PCL: file_rdata = pc_reg[7:0];
        `CSP_ADDR_STATUS: file_rdata = status_reg;
        `CSP_ADDR_POINTER: file_rdata = pointer_reg;
        `CSP_ADDR_TRIM: file_rdata = trim_reg & `CSP_TRIM_MASK;
        default: file_rdata = mem_sel ? mem_rdata : 8'h00;
      endcase
  end

  // status next value
  always @*
  begin
    status_next = status_reg;
    if (file_wr && !self_ref && eff_addr == `CSP_ADDR_STATUS)
    begin
      status_next[`CSP_ST_WAKE] = file_wdata[`CSP_ST_WAKE];
      status_next[`CSP_ST_PAGE] = file_wdata[`CSP_ST_PAGE];
      if (!flags_update)
        status_next[2:0] = file_wdata[2:0];
    end
    if (flags_update)
      status_next[2:0] = flags_result;
    // only sleep and reset logic touch these
    if (timeout_clear)
      status_next[`CSP_ST_TIMEOUT] = 1'b0;
    if (timeout_set)
      status_next[`CSP_ST_TIMEOUT] = 1'b1;
    if (powerdown_clear)
      status_next[`CSP_ST_PWRDN] = 1'b0;
    if (powerdown_set)
      status_next[`CSP_ST_PWRDN] = 1'b1;
    // reset cause lands on the first edge after release
    if (wake_flag_capture)
      status_next[`CSP_ST_WAKE] = wake_reset_cause;
    status_next[6] = 1'b0;
  end

  // program counter next value
  always @*
  begin
    pc_next = pc_inc;
    if (jump_exec)
      pc_next = {2'b00, status_reg[`CSP_ST_PAGE], jump_target};
    else if (call_exec)
      pc_next = {2'b00, status_reg[`CSP_ST_PAGE], 1'b0, call_target};
    else if (return_exec)
      pc_next = stack_level1_reg;
    else if (file_wr && !self_ref && eff_addr == `CSP_ADDR_PCL)
      pc_next = {2'b00, status_reg[`CSP_ST_PAGE], 1'b0, file_wdata};
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_reg <= `CSP_PC_RESET;
      stack_level1_reg <= 12'h000;
      stack_level2_reg <= 12'h000;
      status_reg <= `CSP_STATUS_RESET;
      option_reg <= `CSP_OPTION_RESET;
      trim_reg <= `CSP_TRIM_RESET;
      pointer_reg <= `CSP_POINTER_RESET;
      return_work_data <= 8'h00;
      return_work_valid <= 1'b0;
    end
    else
    begin
      pc_reg <= pc_next;
      status_reg <= status_next;
      return_work_valid <= return_exec;
      if (return_exec)
        return_work_data <= return_literal;
      if (call_exec)
      begin
        stack_level2_reg <= stack_level1_reg;
        stack_level1_reg <= pc_inc;
      end
      else if (return_exec)
        stack_level1_reg <= stack_level2_reg;
      if (option_load)
        option_reg <= work_reg;
      if (file_wr && !self_ref && eff_addr == `CSP_ADDR_TRIM)
        trim_reg <= file_wdata & `CSP_TRIM_MASK;
      if (file_wr && !self_ref && eff_addr == `CSP_ADDR_POINTER)
        pointer_reg <= {1'b1, file_wdata[6:0]};
    end
  end

  // reset cause flag captured one edge after release
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cause_seen_reg <= 1'b0;
    else
      cause_seen_reg <= 1'b1;
  end
  assign wake_flag_capture = !cause_seen_reg;

  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pin
      assign pullup_active[gi] = pin_direction_control[gi] &
        !option_reg[`CSP_OPT_PULLUP_N];
      assign wake_active[gi] = pin_direction_control[gi] &
        !option_reg[`CSP_OPT_WAKE_N];
    end
  endgenerate

  assign timer_clock_source = option_reg[`CSP_OPT_TSRC];
  assign timer_edge_select = option_reg[`CSP_OPT_TEDGE];
  assign prescaler_assign = option_reg[`CSP_OPT_PSA];
  assign prescale_rate = option_reg[2:0];
  assign timer_ratio = 9'h002 << prescale_rate;
  assign wdt_ratio = 8'h01 << prescale_rate;
endmodule

//--- shared/csp_defines.vh
// constants for the core special function register block
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH
`define CSP_ADDR_INDIRECT 5'h00
`define CSP_ADDR_PCL 5'h02
`define CSP_ADDR_STATUS 5'h03
`define CSP_ADDR_POINTER 5'h04
`define CSP_ADDR_TRIM 5'h05
`define CSP_ST_WAKE 7
`define CSP_ST_PAGE 5
`define CSP_ST_TIMEOUT 4
`define CSP_ST_PWRDN 3
`define CSP_ST_ZERO 2
`define CSP_ST_DCARRY 1
`define CSP_ST_CARRY 0
`define CSP_OPT_WAKE_N 7
`define CSP_OPT_PULLUP_N 6
`define CSP_OPT_TSRC 5
`define CSP_OPT_TEDGE 4
`define CSP_OPT_PSA 3
`define CSP_OPTION_RESET 8'hff
`define CSP_TRIM_RESET 8'h80
`define CSP_TRIM_MASK 8'hfc
`define CSP_PC_RESET 12'hfff
`define CSP_POINTER_RESET 8'he0
`define CSP_STATUS_RESET 8'h18
`endif

//--- test/csp_core_sfr_bench.sv
// self-checking bench for the core special function register block
`timescale 1ns/1ps
module csp_core_sfr_bench;
  logic clk_sys, rst_n, wake_reset_cause, timeout_set, timeout_clear, powerdown_set;
  logic powerdown_clear, file_wr, flags_update, option_load, jump_exec, call_exec, return_exec;
  logic [4:0] file_addr;
  logic [7:0] file_wdata, mem_rdata, work_reg, call_target, return_literal;
  logic [2:0] flags_result;
  logic [8:0] jump_target;
  logic [3:0] pin_direction_control;
  wire [7:0] file_rdata, return_work_data, option_reg, trim_reg, status_reg, wdt_ratio;
  wire [6:0] mem_addr;
  wire [11:0] pc_reg, stack_level1_reg, stack_level2_reg;
  wire [3:0] pullup_active, wake_active;
  wire [8:0] timer_ratio;
  wire mem_sel, mem_wr, return_work_valid, timer_clock_source, timer_edge_select, prescaler_assign;
  integer fail_count = 0, checks = 0, seed = 32'h7ff6f176;
  integer pc = 'h3ff, s1 = 'h0, s2 = 'h0, opt = 'hff, page = 'h0, rv, lit, r, i;
  csp_core_sfr csp_core_sfr_i (.*);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // model of pc, stack and option at each edge
  task automatic step;
    @(posedge clk_sys);
    rv = return_exec && !jump_exec && !call_exec;
    lit = return_literal;
    if (option_load)
      opt = work_reg;
    if (jump_exec)
      pc = page * 'h200 + jump_target;
    else if (call_exec)
      {s2, s1, pc} = {s1, (pc + 1) % 'h400, page * 'h200 + call_target};
    else if (return_exec)
      {pc, s1} = {s1, s2};
    else
      pc = (pc + 1) % 'h400;
    #1;
    chk(pc_reg[9:0], pc);
    chk(stack_level1_reg[9:0], s1);
    chk(stack_level2_reg[9:0], s2);
    chk(option_reg, opt);
    chk(return_work_valid, rv);
    if (rv)
      chk(return_work_data, lit);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    {file_wr, file_addr, file_wdata} = {1'h1, a, d};
    step;
    file_wr = 1'h0;
  endtask
  initial
  begin
    {clk_sys, rst_n, wake_reset_cause, timeout_set, timeout_clear, powerdown_set, powerdown_clear,
      file_wr, flags_update, option_load, jump_exec, call_exec, return_exec, file_addr, file_wdata,
      mem_rdata, work_reg, call_target, return_literal, flags_result, jump_target} = '0;
    pin_direction_control = 4'ha;
    repeat (8) @(posedge clk_sys);
    chk(trim_reg, 8'h80);
    chk(pc_reg, 12'hfff);
    #1 rst_n = 1'h1;
    for (page = 0; page < 2; page++)
    begin
      wr(5'h03, {2'h0, page[0], 5'h00});
      chk(status_reg[7:3], {2'h0, page[0], 2'h3});
      for (i = 0; i < 300; i++)
      begin
        r = $random(seed);
        {jump_target, call_target, work_reg, flags_result, option_load} = r[31:3];
        {jump_exec, call_exec, return_exec} = {r[1:0] == 2'h1, r[1:0] == 2'h2, r[1:0] == 2'h3};
        {flags_update, return_literal, pin_direction_control} = {r[2], r[15:8], r[3:0]};
        step;
      end
      {jump_exec, call_exec, return_exec} = 3'h0;
    end
    mem_rdata = 8'h5a;
    wr(5'h04, 8'h00);
    file_addr = 5'h00;
    #1 chk(file_rdata, 8'h00);
    wr(5'h04, 8'h47);
    file_addr = 5'h00;
    #1 chk(mem_addr, 7'h47);
    wr(5'h05, 8'hff);
    chk(trim_reg, 8'hfc);
    {option_load, wake_reset_cause, rst_n} = 3'h2;
    #1 chk(option_reg, 8'hff);
    chk(status_reg[5], 1'h0);
    @(posedge clk_sys);
    #1 rst_n = 1'h1;
    @(posedge clk_sys);
    #1 chk(status_reg[7], 1'h1);
    chk(pc_reg, 12'h000);
    complete_run;
  end
endmodule

//--- test/csp_core_sfr_sva.sv
// assertions for the core special function register block
`timescale 1ns/1ps
module csp_core_sfr_sva (
  input wire clk_sys,
  input wire rst_n,
  input wire option_load,
  input wire [7:0] work_reg,
  input wire [7:0] option_reg,
  input wire jump_exec,
  input wire [8:0] jump_target,
  input wire call_exec,
  input wire [7:0] call_target,
  input wire return_exec,
  input wire flags_update,
  input wire [2:0] flags_result,
  input wire [3:0] pin_direction_control,
  input wire [3:0] pullup_active,
  input wire [7:0] status_reg,
  input wire [8:0] timer_ratio,
  input wire [11:0] pc_reg,
  input wire [11:0] stack_level1_reg,
  input wire [11:0] stack_level2_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  opt_load_a: assert property (option_load |=> option_reg == $past(work_reg))
    else $error("option load lost");
  jump_load_a: assert property (jump_exec |=> pc_reg[9:0] == {$past(status_reg[5]), $past(jump_target)})
    else $error("jump target wrong");
  call_load_a: assert property (call_exec && !jump_exec |=>
    pc_reg[9:0] == {$past(status_reg[5]), 1'h0, $past(call_target)})
    else $error("call target wrong");
  call_push_a: assert property (call_exec && !jump_exec |=> stack_level2_reg == $past(stack_level1_reg)
    && stack_level1_reg == $past(pc_reg) + 12'h1)
    else $error("push wrong");
  ret_pop_a: assert property (return_exec && !jump_exec && !call_exec |=> pc_reg == $past(stack_level1_reg)
    && stack_level1_reg == $past(stack_level2_reg) && $stable(stack_level2_reg))
    else $error("pop wrong");
  flag_force_a: assert property (flags_update |=> status_reg[2:0] == $past(flags_result))
    else $error("flags wrong");
  pullup_gate_a: assert property (pullup_active == (pin_direction_control & {4{~option_reg[6]}}))
    else $error("pull-up wrong");
  ratio_sel_a: assert property (timer_ratio == 9'h2 << option_reg[2:0])
    else $error("ratio wrong");
  cover property (call_exec ##1 call_exec ##1 call_exec);
  cover property (return_exec ##1 return_exec ##1 return_exec);
  cover property (option_load && !work_reg[6]);
endmodule
bind csp_core_sfr csp_core_sfr_sva csp_core_sfr_sva_i (.*);
